// ==== verilog/lcdp_map.vh ====
/*
 * Register indices, field positions, reset values and timing counts of the
 * LCD power and segment port control block.
 * Assumes inclusion by bare name from every design file that needs them.
 */
`ifndef LCDP_MAP_VH
`define LCDP_MAP_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define LCDP_CTRL_IDX          12'h013
`define LCDP_PORT_IDX          12'h015
`define LCDP_STAT_IDX          12'h016
`define LCDP_RAM_IDX           12'h300
`define LCDP_RAM_WORDS         34

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define LCDP_HEAVY_BIT         1
`define LCDP_DISABLE_BIT       2
`define LCDP_THIRD_SEL_BIT     1
`define LCDP_FOURTH_SEL_BIT    2
`define LCDP_PULLUP_BIT        3
`define LCDP_CTRL_RESET        4'h4
`define LCDP_PORT_RESET        4'h0

// ----------------------------------------------------------------------
// Timing: frame rates in Hz and derived cycles per common phase
// ----------------------------------------------------------------------
`define LCDP_CLK_HZ            200000000
`define LCDP_FRAME_HZ_3COM     43
`define LCDP_FRAME_HZ_4COM     32
`define LCDP_HALF_HZ_3COM      21
`define LCDP_HALF_HZ_4COM      16
`define LCDP_PHASE_FULL_3COM   (`LCDP_CLK_HZ / (`LCDP_FRAME_HZ_3COM * 3))
`define LCDP_PHASE_FULL_4COM   (`LCDP_CLK_HZ / (`LCDP_FRAME_HZ_4COM * 4))
`define LCDP_PHASE_HALF_3COM   (`LCDP_CLK_HZ / (`LCDP_HALF_HZ_3COM * 3))
`define LCDP_PHASE_HALF_4COM   (`LCDP_CLK_HZ / (`LCDP_HALF_HZ_4COM * 4))
`define LCDP_PUMP_SETTLE       8

`endif

// ==== verilog/lcdp_frame_gen.v ====
/*
 * Common-phase sequencer: steps through three or four commons and flips
 * the drive polarity once per frame.
 * Assumes an asynchronous active-low reset and a clock enable from the top.
 */
`default_nettype none

module lcdp_frame_gen #(
    parameter [31:0] PHASE_CYCLES = 32'd1562500
) (
    input  wire        clk_in,
    input  wire        rst_n_in,
    input  wire        ce_in,
    input  wire        run_in,
    input  wire        four_com_in,
    output reg  [1:0]  phase_out,
    output reg         polarity_out
);

    reg [31:0] count;
    wire       last_phase = four_com_in ? (phase_out == 2'h3) : (phase_out == 2'h2);

    // ------------------------------------------------------------------
    // Phase counter
    // ------------------------------------------------------------------
    // Held at phase zero while the panel is dark so a fresh frame starts clean
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count        <= 32'h0;
            phase_out    <= 2'h0;
            polarity_out <= 1'b0;
        end else if (ce_in) begin
            if (!run_in) begin
                count        <= 32'h0;
                phase_out    <= 2'h0;
                polarity_out <= 1'b0;
            end else if (count >= PHASE_CYCLES - 32'h1) begin
                count <= 32'h0;
                if (last_phase) begin
                    phase_out    <= 2'h0;
                    polarity_out <= ~polarity_out;
                end else begin
                    phase_out <= phase_out + 2'h1;
                end
            end else begin
                count <= count + 32'h1;
            end
        end
    end

endmodule // lcdp_frame_gen

`default_nettype wire

// ==== verilog/lcdp_top.v ====
/*
 * LCD power and segment port control: pump and display sequencing, the
 * port/segment register, the display RAM and the common/segment drivers,
 * all behind an AXI4-Lite slave.
 * Assumes synchronous event pulses from the CPU side and a single clock.
 */
// Notes on behaviour
// - Third port select set: third port pins carry segments 27 to 30.
// - Fourth port select set: fourth port pins carry segments 31 to 34.
// - Port register bit three is read/write pull-up enable.
// - Full frame mode: about 43 Hz three-common, 32 Hz four-common.
// - RC halved frame mode: about 21 Hz and 16 Hz.
// - Stop event turns off pump and display.
// - Non-solar: pad reset or power-on sets disable bit, display off.
// - Non-solar: pump on once bit cleared, off only by stop or watchdog reset event.
// - Non-solar: writing one blanks display only, pump keeps running.
// - Solar: power-on sets disable bit, pump and display off.
// - Solar: clearing bit starts pump first, then display.
// - Solar: writing one turns off pump and display.
// - Solar: pad reset leaves bit, pump and display unchanged.
// - Heavy-load bit only acts with the crystal oscillator.
// - Three-common mode: fourth common copies first common.
// - LCD off: all commons and segments driven low.
`default_nettype none
`include "lcdp_map.vh"

module lcdp_top #(
    parameter        SOLAR_SUPPLY       = 0,
    parameter        RC_CLOCK           = 0,
    parameter        HALF_FRAME         = 0,
    parameter        FOUR_COM           = 1,
    parameter [31:0] PHASE_FULL_3COM    = `LCDP_PHASE_FULL_3COM,
    parameter [31:0] PHASE_FULL_4COM    = `LCDP_PHASE_FULL_4COM,
    parameter [31:0] PHASE_HALF_3COM    = `LCDP_PHASE_HALF_3COM,
    parameter [31:0] PHASE_HALF_4COM    = `LCDP_PHASE_HALF_4COM,
    parameter [7:0]  PUMP_SETTLE_CYCLES = `LCDP_PUMP_SETTLE
) (
    input  wire        CLK_IN,
    input  wire        RESET_N_IN,
    input  wire        CE_IN,
    input  wire        PAD_RESET_IN,
    input  wire        WATCHDOG_RESET_EVENT_IN,
    input  wire        STOP_EVENT_IN,
    input  wire [11:0] S_AXI_AWADDR_IN,
    input  wire        S_AXI_AWVALID_IN,
    output wire        S_AXI_AWREADY_OUT,
    input  wire [31:0] S_AXI_WDATA_IN,
    input  wire [3:0]  S_AXI_WSTRB_IN,
    input  wire        S_AXI_WVALID_IN,
    output wire        S_AXI_WREADY_OUT,
    output reg  [1:0]  S_AXI_BRESP_OUT,
    output reg         S_AXI_BVALID_OUT,
    input  wire        S_AXI_BREADY_IN,
    input  wire [11:0] S_AXI_ARADDR_IN,
    input  wire        S_AXI_ARVALID_IN,
    output wire        S_AXI_ARREADY_OUT,
    output reg  [31:0] S_AXI_RDATA_OUT,
    output reg  [1:0]  S_AXI_RRESP_OUT,
    output reg         S_AXI_RVALID_OUT,
    input  wire        S_AXI_RREADY_IN,
    input  wire [3:0]  THIRD_IO_PORT_DATA_IN,
    input  wire [3:0]  THIRD_IO_PORT_OE_IN,
    input  wire [3:0]  FOURTH_IO_PORT_DATA_IN,
    input  wire [3:0]  FOURTH_IO_PORT_OE_IN,
    output reg  [3:0]  THIRD_IO_PORT_PIN_OUT,
    output reg  [3:0]  THIRD_IO_PORT_OE_OUT,
    output reg  [3:0]  FOURTH_IO_PORT_PIN_OUT,
    output reg  [3:0]  FOURTH_IO_PORT_OE_OUT,
    output reg  [3:0]  COM_OUT,
    output reg  [25:0] SEG_OUT,
    output wire        PUMP_ON_OUT,
    output wire        DISPLAY_ON_OUT,
    output wire        PULLUP_ENABLE_OUT,
    output wire        HEAVY_LOAD_OUT
);

    localparam [1:0] ST_OFF  = 2'h0;
    localparam [1:0] ST_PUMP = 2'h1;
    localparam [1:0] ST_ON   = 2'h2;
    localparam [1:0] RESP_OKAY = 2'h0;
    localparam [1:0] RESP_SLVERR = 2'h2;
    localparam [3:0] CTRL_RST    = `LCDP_CTRL_RESET;
    localparam [31:0] PHASE_CYCLES = (HALF_FRAME != 0 && RC_CLOCK != 0) ?
        (FOUR_COM != 0 ? PHASE_HALF_4COM : PHASE_HALF_3COM) :
        (FOUR_COM != 0 ? PHASE_FULL_4COM : PHASE_FULL_3COM);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    reg rst_meta;
    reg rst_n;
    always @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ------------------------------------------------------------------
    // Address helpers
    // ------------------------------------------------------------------
    function [11:0] byte_addr;
        input [11:0] idx;
        begin
            byte_addr = {idx[9:0], 2'b00};
        end
    endfunction

    function ram_hit;
        input [11:0] addr;
        begin
            ram_hit = (addr[11:2] >= `LCDP_RAM_IDX) &&
                      (addr[11:2] < `LCDP_RAM_IDX + `LCDP_RAM_WORDS);
        end
    endfunction

    function [5:0] ram_slot;
        input [11:0] addr;
        reg   [11:0] off;
        begin
            off      = {2'b00, addr[11:2]} - `LCDP_RAM_IDX;
            ram_slot = off[5:0];
        end
    endfunction

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    reg        display_disable_bit;
    reg        heavy_load_select;
    reg        pullup_enable_bit;
    reg        third_port_segment_select;
    reg        fourth_port_segment_select;
    reg [1:0]  pwr_state;
    reg [7:0]  settle;
    reg [3:0]  ram [0:`LCDP_RAM_WORDS-1];
    wire [1:0] phase;
    wire       polarity;
    integer    i;
    integer    j;

    // ------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------
    reg        aw_held;
    reg        w_held;
    reg [11:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0]  w_strb;
    assign S_AXI_AWREADY_OUT = !aw_held && !S_AXI_BVALID_OUT;
    assign S_AXI_WREADY_OUT  = !w_held && !S_AXI_BVALID_OUT;
    wire   do_write = aw_held && w_held && !S_AXI_BVALID_OUT;
    wire   lane0    = do_write && w_strb[0];
    wire   wr_ctrl  = lane0 && aw_addr == byte_addr(`LCDP_CTRL_IDX);
    wire   wr_port  = lane0 && aw_addr == byte_addr(`LCDP_PORT_IDX);
    wire   wr_ram   = lane0 && ram_hit(aw_addr);
    wire   mapped_w = aw_addr == byte_addr(`LCDP_CTRL_IDX) ||
                      aw_addr == byte_addr(`LCDP_PORT_IDX) ||
                      aw_addr == byte_addr(`LCDP_STAT_IDX) || ram_hit(aw_addr);

    always @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            aw_held          <= 1'b0;
            w_held           <= 1'b0;
            aw_addr          <= 12'h000;
            w_data           <= 32'h0000_0000;
            w_strb           <= 4'h0;
            S_AXI_BVALID_OUT <= 1'b0;
            S_AXI_BRESP_OUT  <= RESP_OKAY;
        end else if (CE_IN) begin
            if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
                aw_held <= 1'b1;
                aw_addr <= S_AXI_AWADDR_IN;
            end
            if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
                w_held <= 1'b1;
                w_data <= S_AXI_WDATA_IN;
                w_strb <= S_AXI_WSTRB_IN;
            end
            if (do_write) begin
                aw_held          <= 1'b0;
                w_held           <= 1'b0;
                S_AXI_BVALID_OUT <= 1'b1;
                S_AXI_BRESP_OUT  <= mapped_w ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
                S_AXI_BVALID_OUT <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Configuration bits and display RAM
    // ------------------------------------------------------------------
    always @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            heavy_load_select          <= CTRL_RST[`LCDP_HEAVY_BIT];
            pullup_enable_bit          <= 1'b0;
            third_port_segment_select  <= 1'b0;
            fourth_port_segment_select <= 1'b0;
            for (i = 0; i < `LCDP_RAM_WORDS; i = i + 1) begin
                ram[i] <= 4'h0;
            end
        end else if (CE_IN) begin
            if (wr_ctrl) begin
                heavy_load_select <= w_data[`LCDP_HEAVY_BIT];
            end
            if (wr_port) begin
                pullup_enable_bit          <= w_data[`LCDP_PULLUP_BIT];
                third_port_segment_select  <= w_data[`LCDP_THIRD_SEL_BIT];
                fourth_port_segment_select <= w_data[`LCDP_FOURTH_SEL_BIT];
            end
            if (wr_ram) begin
                ram[ram_slot(aw_addr)] <= w_data[3:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Disable bit and pump/display sequencer
    // ------------------------------------------------------------------
    // Hardware events outrank a same-cycle software clear, so a stop never
    // gets lost behind a write
    wire hard_off = STOP_EVENT_IN || WATCHDOG_RESET_EVENT_IN;
    wire pad_hit  = PAD_RESET_IN && (SOLAR_SUPPLY == 0);
    reg  next_disable;
    reg  [1:0] next_state;

    always @* begin
        next_disable = display_disable_bit;
        if (wr_ctrl) begin
            next_disable = w_data[`LCDP_DISABLE_BIT];
        end
        if (hard_off || pad_hit) begin
            next_disable = 1'b1;
        end
        next_state = pwr_state;
        if (hard_off) begin
            next_state = ST_OFF;
        end else begin
            case (pwr_state)
                ST_OFF: begin
                    if (!next_disable) begin
                        next_state = ST_PUMP;
                    end
                end
                ST_PUMP: begin
                    if (next_disable && SOLAR_SUPPLY != 0) begin
                        next_state = ST_OFF;
                    end else if (!next_disable && settle >= PUMP_SETTLE_CYCLES - 8'h1) begin
                        next_state = ST_ON;
                    end
                end
                ST_ON: begin
                    if (next_disable) begin
                        next_state = (SOLAR_SUPPLY != 0) ? ST_OFF : ST_PUMP;
                    end
                end
                default: begin
                    next_state = ST_OFF;
                end
            endcase
        end
    end

    // Power-on lands in the off state with the bit set under either option
    always @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            display_disable_bit <= 1'b1;
            pwr_state           <= ST_OFF;
            settle              <= 8'h00;
        end else if (CE_IN) begin
            display_disable_bit <= next_disable;
            pwr_state           <= next_state;
            settle              <= (pwr_state == ST_PUMP && next_state == ST_PUMP &&
                                    settle != 8'hff) ? settle + 8'h1 : 8'h00;
        end
    end

    assign PUMP_ON_OUT       = pwr_state != ST_OFF;
    assign DISPLAY_ON_OUT    = pwr_state == ST_ON;
    assign PULLUP_ENABLE_OUT = pullup_enable_bit;
    // Extra drive only helps a crystal; the RC oscillator ignores it
    assign HEAVY_LOAD_OUT    = heavy_load_select && (RC_CLOCK == 0);

    // ------------------------------------------------------------------
    // Frame sequencer and drivers
    // ------------------------------------------------------------------
    lcdp_frame_gen #(
        .PHASE_CYCLES (PHASE_CYCLES)
    ) u_frame (
        .clk_in       (CLK_IN),
        .rst_n_in     (rst_n),
        .ce_in        (CE_IN),
        .run_in       (DISPLAY_ON_OUT),
        .four_com_in  (FOUR_COM != 0),
        .phase_out    (phase),
        .polarity_out (polarity)
    );

    reg [3:0]  next_com;
    reg [33:0] next_seg;
    always @* begin
        next_com = 4'h0;
        next_seg = 34'h0;
        if (DISPLAY_ON_OUT) begin
            for (j = 0; j < 4; j = j + 1) begin
                next_com[j] = (phase == j[1:0]) ^ polarity;
            end
            if (FOUR_COM == 0) begin
                next_com[3] = next_com[0];
            end
            for (j = 0; j < `LCDP_RAM_WORDS; j = j + 1) begin
                next_seg[j] = ram[j][phase] ^ polarity;
            end
        end
    end

    // Dark panel means every line low, including the borrowed port pins
    always @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            COM_OUT                <= 4'h0;
            SEG_OUT                <= 26'h0;
            THIRD_IO_PORT_PIN_OUT  <= 4'h0;
            THIRD_IO_PORT_OE_OUT   <= 4'h0;
            FOURTH_IO_PORT_PIN_OUT <= 4'h0;
            FOURTH_IO_PORT_OE_OUT  <= 4'h0;
        end else if (CE_IN) begin
            COM_OUT <= next_com;
            SEG_OUT <= next_seg[25:0];
            if (third_port_segment_select) begin
                THIRD_IO_PORT_PIN_OUT <= next_seg[29:26];
                THIRD_IO_PORT_OE_OUT  <= 4'hf;
            end else begin
                THIRD_IO_PORT_PIN_OUT <= THIRD_IO_PORT_DATA_IN;
                THIRD_IO_PORT_OE_OUT  <= THIRD_IO_PORT_OE_IN;
            end
            if (fourth_port_segment_select) begin
                FOURTH_IO_PORT_PIN_OUT <= next_seg[33:30];
                FOURTH_IO_PORT_OE_OUT  <= 4'hf;
            end else begin
                FOURTH_IO_PORT_PIN_OUT <= FOURTH_IO_PORT_DATA_IN;
                FOURTH_IO_PORT_OE_OUT  <= FOURTH_IO_PORT_OE_IN;
            end
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------
    assign S_AXI_ARREADY_OUT = !S_AXI_RVALID_OUT;
    always @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            S_AXI_RVALID_OUT <= 1'b0;
            S_AXI_RDATA_OUT  <= 32'h0000_0000;
            S_AXI_RRESP_OUT  <= RESP_OKAY;
        end else if (CE_IN) begin
            if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
                S_AXI_RVALID_OUT <= 1'b1;
                S_AXI_RRESP_OUT  <= RESP_OKAY;
                S_AXI_RDATA_OUT  <= 32'h0000_0000;
                if (S_AXI_ARADDR_IN == byte_addr(`LCDP_CTRL_IDX)) begin
                    S_AXI_RDATA_OUT[3:0] <= {1'b0, display_disable_bit,
                                             heavy_load_select, 1'b0};
                end else if (S_AXI_ARADDR_IN == byte_addr(`LCDP_PORT_IDX)) begin
                    S_AXI_RDATA_OUT[3:0] <= {pullup_enable_bit, fourth_port_segment_select,
                                             third_port_segment_select, 1'b0};
                end else if (S_AXI_ARADDR_IN == byte_addr(`LCDP_STAT_IDX)) begin
                    S_AXI_RDATA_OUT[3:0] <= {phase, DISPLAY_ON_OUT, PUMP_ON_OUT};
                end else if (ram_hit(S_AXI_ARADDR_IN)) begin
                    S_AXI_RDATA_OUT[3:0] <= ram[ram_slot(S_AXI_ARADDR_IN)];
                end else begin
                    S_AXI_RRESP_OUT <= RESP_SLVERR;
                end
            end else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN) begin
                S_AXI_RVALID_OUT <= 1'b0;
            end
        end
    end

endmodule // lcdp_top

`default_nettype wire

// ==== verification/lcdp_chk_assertions.sv ====
/* Checker for the LCD power control block.
   Assumes it is bound to lcdp_top, three-common build, CE_IN high. */
`default_nettype none
module lcdp_chk (
    input wire logic        CLK_IN,
    input wire logic        RESET_N_IN,
    input wire logic        PAD_RESET_IN,
    input wire logic        WATCHDOG_RESET_EVENT_IN,
    input wire logic        STOP_EVENT_IN,
    input wire logic [3:0]  COM_OUT,
    input wire logic [25:0] SEG_OUT,
    input wire logic        PUMP_ON_OUT,
    input wire logic        DISPLAY_ON_OUT
);
    // ------------------------------------------------------------
    // Power sequencing and drive
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!RESET_N_IN);
    ev_off_a: assert property ((STOP_EVENT_IN || WATCHDOG_RESET_EVENT_IN) |=>
        !PUMP_ON_OUT && !DISPLAY_ON_OUT) else $error("pump or display on after event");
    pad_blank_a: assert property (PAD_RESET_IN |=>
        !DISPLAY_ON_OUT && $stable(PUMP_ON_OUT)) else $error("pad reset effect wrong");
    pump_hold_a: assert property (PUMP_ON_OUT && !STOP_EVENT_IN &&
        !WATCHDOG_RESET_EVENT_IN |=> PUMP_ON_OUT) else $error("pump dropped");
    settle_wait_a: assert property ($rose(PUMP_ON_OUT) |->
        !DISPLAY_ON_OUT [*8]) else $error("display came on too early");
    pump_first_a: assert property ($rose(DISPLAY_ON_OUT) |->
        $past(PUMP_ON_OUT, 8)) else $error("pump not settled before display");
    disp_pump_a: assert property (DISPLAY_ON_OUT |-> PUMP_ON_OUT)
        else $error("display on without pump");
    off_low_a: assert property (!DISPLAY_ON_OUT |=>
        COM_OUT == 4'h0 && SEG_OUT == 26'h0) else $error("drive not low while off");
    com_copy_a: assert property (COM_OUT[3] == COM_OUT[0])
        else $error("fourth common differs from first");
    cover property ($rose(DISPLAY_ON_OUT));
    cover property (STOP_EVENT_IN && PUMP_ON_OUT);
    cover property (PAD_RESET_IN && DISPLAY_ON_OUT);
endmodule // lcdp_chk
bind lcdp_top lcdp_chk u_chk (.CLK_IN, .RESET_N_IN, .PAD_RESET_IN, .WATCHDOG_RESET_EVENT_IN,
    .STOP_EVENT_IN, .COM_OUT, .SEG_OUT, .PUMP_ON_OUT, .DISPLAY_ON_OUT);
`default_nettype wire

// ==== verification/lcdp_panel.sv ====
/* Panel model: recovers the lit pattern seen under each common.
   Assumes three commons, polarity inverted on alternate frames. */
`default_nettype none
module lcdp_panel (
    input  wire logic        clk_in,
    input  wire logic [3:0]  com_in,
    input  wire logic [25:0] seg_in,
    output var  logic [77:0] pix_out
);
    // ------------------------------------------------------------
    // Active common is the one unlike the other two
    // ------------------------------------------------------------
    always @(posedge clk_in) begin
        for (int k = 0; k < 3; k++) begin
            automatic logic other = com_in[(k + 1) % 3];
            if (com_in[k] != other && other == com_in[(k + 2) % 3]) begin
                pix_out[26 * k +: 26] <= seg_in ^ {26{~com_in[k]}};
            end
        end
    end
endmodule // lcdp_panel
`default_nettype wire

// ==== verification/tb_top.sv ====
/* Bench: AXI4-Lite master, event pulses and panel model around lcdp_top.
   Assumes the non-solar crystal build with short common phases. */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic CLK_IN = 0, RESET_N_IN = 0, CE_IN = 1, PAD_RESET_IN = 0;
    logic WATCHDOG_RESET_EVENT_IN = 0, STOP_EVENT_IN = 0, S_AXI_BREADY_IN = 0;
    logic S_AXI_AWVALID_IN = 0, S_AXI_WVALID_IN = 0, S_AXI_ARVALID_IN = 0, S_AXI_RREADY_IN = 0;
    logic [11:0] S_AXI_AWADDR_IN = 0, S_AXI_ARADDR_IN = 0;
    logic [31:0] S_AXI_WDATA_IN = 0, rd_q;
    logic [3:0] S_AXI_WSTRB_IN = 4'hf, THIRD_IO_PORT_DATA_IN = 0, THIRD_IO_PORT_OE_IN = 0;
    logic [3:0] FOURTH_IO_PORT_DATA_IN = 0, FOURTH_IO_PORT_OE_IN = 0, v, ram [26];
    wire logic S_AXI_AWREADY_OUT, S_AXI_WREADY_OUT, S_AXI_BVALID_OUT, S_AXI_ARREADY_OUT;
    wire logic S_AXI_RVALID_OUT, PUMP_ON_OUT, DISPLAY_ON_OUT, PULLUP_ENABLE_OUT, HEAVY_LOAD_OUT;
    wire logic [1:0] S_AXI_BRESP_OUT, S_AXI_RRESP_OUT;
    wire logic [3:0] THIRD_IO_PORT_PIN_OUT, THIRD_IO_PORT_OE_OUT, COM_OUT;
    wire logic [3:0] FOURTH_IO_PORT_PIN_OUT, FOURTH_IO_PORT_OE_OUT;
    wire logic [31:0] S_AXI_RDATA_OUT;
    wire logic [25:0] SEG_OUT;
    wire logic [77:0] pix;
    integer err_count = 0, samples_checked = 0, seed = 64403, i;
    // Short phases keep a frame at twelve cycles
    lcdp_top #(.FOUR_COM(0), .PHASE_FULL_3COM(32'h4), .PHASE_FULL_4COM(32'h4),
        .PHASE_HALF_3COM(32'h4), .PHASE_HALF_4COM(32'h4)) dut (.*);
    lcdp_panel panel (.clk_in(CLK_IN), .com_in(COM_OUT), .seg_in(SEG_OUT), .pix_out(pix));
    initial forever #2.5 CLK_IN = ~CLK_IN;
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t %h %h", $time, seen, exp);
        end
    endtask
    task final_report;
        if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task tmo(input integer c);
        if (c >= 64) begin
            chk(c, 0);
            final_report;
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        integer c;
        c = 0;
        @(posedge CLK_IN);
        S_AXI_AWADDR_IN <= a;
        S_AXI_WDATA_IN <= d;
        S_AXI_AWVALID_IN <= 1'h1;
        S_AXI_WVALID_IN <= 1'h1;
        S_AXI_BREADY_IN <= 1'h1;
        do begin
            @(posedge CLK_IN);
            c++;
            if (S_AXI_AWREADY_OUT) S_AXI_AWVALID_IN <= 1'h0;
            if (S_AXI_WREADY_OUT) S_AXI_WVALID_IN <= 1'h0;
        end while (S_AXI_BVALID_OUT !== 1'h1 && c < 64);
        S_AXI_BREADY_IN <= 1'h0;
        tmo(c);
        chk(32'(S_AXI_BRESP_OUT), 32'(er));
        #11;
    endtask
    task rd(input logic [11:0] a, input logic [1:0] er);
        integer c;
        c = 0;
        @(posedge CLK_IN);
        S_AXI_ARADDR_IN <= a;
        S_AXI_ARVALID_IN <= 1'h1;
        S_AXI_RREADY_IN <= 1'h1;
        do begin
            @(posedge CLK_IN);
            c++;
            if (S_AXI_ARREADY_OUT) S_AXI_ARVALID_IN <= 1'h0;
        end while (S_AXI_RVALID_OUT !== 1'h1 && c < 64);
        rd_q = S_AXI_RDATA_OUT;
        S_AXI_RREADY_IN <= 1'h0;
        tmo(c);
        chk(32'(S_AXI_RRESP_OUT), 32'(er));
    endtask
    task rst;
        RESET_N_IN <= 1'h0;
        repeat (3) @(posedge CLK_IN);
        RESET_N_IN <= 1'h1;
        repeat (3) @(posedge CLK_IN);
        rd(12'h04c, 2'h0);
        chk(rd_q, 32'h4);
        rd(12'h058, 2'h0);
        chk(rd_q & 32'h3, 32'h0);
    endtask
    task on_wait;
        integer c;
        c = 0;
        wr(12'h04c, 32'h0, 2'h0);
        while (DISPLAY_ON_OUT !== 1'h1 && c < 64) begin
            @(posedge CLK_IN);
            c++;
        end
        tmo(c);
        #1;
    endtask
    task pulse(input integer k);
        @(posedge CLK_IN);
        PAD_RESET_IN <= (k == 0);
        WATCHDOG_RESET_EVENT_IN <= (k == 1);
        STOP_EVENT_IN <= (k == 2);
        @(posedge CLK_IN);
        PAD_RESET_IN <= 1'h0;
        WATCHDOG_RESET_EVENT_IN <= 1'h0;
        STOP_EVENT_IN <= 1'h0;
        #1;
    endtask
    function automatic logic [25:0] expix(input integer k);
        for (int s = 0; s < 26; s++) expix[s] = ram[s][k];
    endfunction
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        rst;
        for (i = 0; i < 6; i++) begin
            v = (i == 5) ? 4'hf : 4'($random(seed));
            THIRD_IO_PORT_DATA_IN <= 4'($random(seed));
            THIRD_IO_PORT_OE_IN <= 4'($random(seed));
            FOURTH_IO_PORT_DATA_IN <= 4'($random(seed));
            FOURTH_IO_PORT_OE_IN <= 4'($random(seed));
            wr(12'h054, 32'(v), 2'h0);
            rd(12'h054, 2'h0);
            chk(rd_q, 32'(v & 4'he));
            #1;
            chk(32'(PULLUP_ENABLE_OUT), 32'(v[3]));
            chk(32'({THIRD_IO_PORT_PIN_OUT, THIRD_IO_PORT_OE_OUT}), 32'(v[1] ? 8'h0f :
                {THIRD_IO_PORT_DATA_IN, THIRD_IO_PORT_OE_IN}));
            chk(32'({FOURTH_IO_PORT_PIN_OUT, FOURTH_IO_PORT_OE_OUT}), 32'(v[2] ? 8'h0f :
                {FOURTH_IO_PORT_DATA_IN, FOURTH_IO_PORT_OE_IN}));
        end
        wr(12'h100, 32'h5, 2'h2);
        rd(12'h100, 2'h2);
        chk(rd_q, 32'h0);
        for (i = 0; i < 26; i++) begin
            ram[i] = (i == 0) ? 4'hf : 4'($random(seed));
            wr(12'hc00 + 12'(4 * i), 32'(ram[i]), 2'h0);
        end
        rd(12'hc64, 2'h0);
        chk(rd_q, 32'(ram[25]));
        on_wait;
        chk(32'(PUMP_ON_OUT), 32'h1);
        repeat (30) @(posedge CLK_IN);
        #1;
        for (i = 0; i < 3; i++) chk(32'(pix[26 * i +: 26]), 32'(expix(i)));
        wr(12'h04c, 32'h2, 2'h0);
        chk(32'(HEAVY_LOAD_OUT), 32'h1);
        wr(12'h04c, 32'h4, 2'h0);
        chk(32'({PUMP_ON_OUT, DISPLAY_ON_OUT}), 32'h2);
        for (i = 0; i < 3; i++) begin
            on_wait;
            pulse(i);
            chk(32'({PUMP_ON_OUT, DISPLAY_ON_OUT}), 32'(i ? 0 : 2));
            rd(12'h04c, 2'h0);
            chk(rd_q & 32'h4, 32'h4);
        end
        on_wait;
        rst;
        final_report;
    end
endmodule // tb_top
`default_nettype wire
